// ---- design/usdp_pkg.sv ----
// Constants shared by the UART shadow data port.
`default_nettype none
package usdp_pkg;
  // Two documented alias addresses; the other fourteen sit around them at a word stride.
  localparam logic [31:0] ADDR_ALIAS_DATA_11 = 32'h5000_115c;
  localparam logic [31:0] ADDR_ALIAS_DATA_12 = 32'h5000_1160;
  localparam logic [31:0] ALIAS_STRIDE       = 32'h0000_0004;
  localparam logic [31:0] ALIAS_11_INDEX     = 32'h0000_000b;
  localparam logic [31:0] DATA_BASE          =
    32'(ADDR_ALIAS_DATA_11 - ALIAS_11_INDEX * ALIAS_STRIDE);
  localparam logic [31:0] ALIAS_SPAN         = 32'h0000_0040;
  localparam logic [31:0] CTRL_OFS           = 32'h0000_0040;
  localparam logic [31:0] STAT_OFS           = 32'h0000_0044;
  localparam int          FIFO_DEPTH         = 16;
  localparam int          CHAR_W             = 8;
  localparam int          CTRL_FIFO_EN_BIT   = 0;
  localparam int          CTRL_IR_MODE_BIT   = 1;
  localparam int          STAT_DR_BIT        = 0;
  localparam int          STAT_OVR_BIT       = 1;
  localparam int          STAT_TX_HOLDING_EMPTY_FLAG_BIT      = 5;
  localparam logic        FIFO_EN_RESET      = 1'b0;
  localparam logic        IR_MODE_RESET      = 1'b0;
  localparam logic [7:0]  CHAR_RESET         = 8'h00;
  localparam logic [31:0] RDATA_RESET        = 32'h0000_0000;
  localparam logic        HRESP_OKAY         = 1'b0;
endpackage
`default_nettype wire

// ---- design/usdp_data_port.sv ----
// UART shadow data port: aliased receive/transmit data window behind AHB-Lite.
//
// What this block does
// R1 - Sixteen 32-bit aliased data locations; data byte sits in bits 7:0.
// R2 - Read returns byte received on serial input, or infrared input in IR mode.
// R3 - Software trusts read data only while data-ready flag is set.
// R4 - FIFO disabled: new character overwrites unread one and flags overrun.
// R5 - FIFO enabled: read returns head of receive FIFO.
// R6 - Receive FIFO full: keep contents, drop new character, flag overrun.
// R7 - Write supplies character for serial output, or infrared output in IR mode.
// R8 - Software writes transmit data only while holding-empty flag is set.
// R9 - FIFO disabled: write clears holding-empty; further writes overwrite pending data.
// R10 - FIFO enabled: writes accepted up to configured depth, sixteen by default.
// R11 - Writes while transmit FIFO is full are dropped, contents unchanged.
// R12 - Every alias reaches the same receive and transmit storage.
`default_nettype none
module usdp_data_port #(
  parameter int DEPTH = usdp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Characters from the serial and infrared receivers
  input  wire logic [7:0]  ser_rx_char,
  input  wire logic        ser_rx_valid,
  input  wire logic [7:0]  ir_rx_char,
  input  wire logic        ir_rx_valid,
  // Character to the transmitter
  output logic [7:0]       tx_char,
  output logic             tx_char_valid,
  input  wire logic        tx_char_take,
  output logic             tx_ir_mode,
  // Line status bits
  output logic             rx_data_ready_flag,
  output logic             tx_holding_empty_flag,
  output logic             overrun_flag,
  output logic             fifo_enable
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [CW-1:0] ONE  = CW'(1);

  logic [7:0]    rx_mem [DEPTH];
  logic [7:0]    tx_mem [DEPTH];
  logic [AW-1:0] rx_rd, rx_wr, tx_rd, tx_wr;
  logic [CW-1:0] rx_cnt, tx_cnt;
  logic          wr_pend, wr_alias, wr_ctrl;
  logic [AW-1:0] next_rx_rd, next_rx_wr, next_tx_rd, next_tx_wr;
  logic [CW-1:0] next_rx_cnt, next_tx_cnt;
  logic          next_wr_pend, next_wr_alias, next_wr_ctrl;
  logic [31:0]   next_hrdata;
  logic [7:0]    next_tx_char;
  logic          next_tx_char_valid, next_tx_ir_mode, next_overrun, next_fifo_enable;
  logic          rx_we, tx_we;
  logic [AW-1:0] rx_waddr, tx_waddr;
  logic [7:0]    rx_wdata, in_char;
  logic          in_valid, acc, rd_alias, rx_pop, tx_pop, tx_push;
  logic [31:0]   off;
  logic [7:0]    rx_head, tx_head;

  assign rx_head = rx_mem[rx_rd];
  assign tx_head = tx_mem[tx_rd];

  always_comb begin
    next_rx_rd         = rx_rd;
    next_rx_wr         = rx_wr;
    next_rx_cnt        = rx_cnt;
    next_tx_rd         = tx_rd;
    next_tx_wr         = tx_wr;
    next_tx_cnt        = tx_cnt;
    next_tx_char       = tx_char;
    next_tx_char_valid = tx_char_valid;
    next_tx_ir_mode    = tx_ir_mode;
    next_fifo_enable   = fifo_enable;
    next_overrun       = overrun_flag;
    next_hrdata        = usdp_pkg::RDATA_RESET;
    // The receive source is chosen first so the write data never sees a stale pick.
    in_valid           = tx_ir_mode ? ir_rx_valid : ser_rx_valid; // [R2]
    in_char            = tx_ir_mode ? ir_rx_char : ser_rx_char; // [R2]
    rx_we              = 1'b0;
    rx_waddr           = rx_wr;
    rx_wdata           = in_char;
    tx_we              = 1'b0;
    tx_waddr           = tx_wr;
    // Only whole-word transfers are issued, so byte lanes are not decoded.
    acc           = hsel & hready & htrans[1];
    off           = haddr - usdp_pkg::DATA_BASE;
    next_wr_pend  = acc & hwrite;
    next_wr_alias = off < usdp_pkg::ALIAS_SPAN; // [R12]
    next_wr_ctrl  = off == usdp_pkg::CTRL_OFS;
    rd_alias      = acc & ~hwrite & (off < usdp_pkg::ALIAS_SPAN); // [R1] [R12]
    rx_pop        = rd_alias & (rx_cnt != '0);
    if (rd_alias) begin
      next_hrdata[7:0] = rx_head; // [R1] [R5]
    end
    if (acc & ~hwrite & next_wr_ctrl) begin
      next_hrdata[usdp_pkg::CTRL_FIFO_EN_BIT] = fifo_enable;
      next_hrdata[usdp_pkg::CTRL_IR_MODE_BIT] = tx_ir_mode;
    end
    // Status read clears the overrun flag; a new overrun below still sets it.
    if (acc & ~hwrite & (off == usdp_pkg::STAT_OFS)) begin
      next_hrdata[usdp_pkg::STAT_DR_BIT]   = rx_cnt != '0;
      next_hrdata[usdp_pkg::STAT_OVR_BIT]  = overrun_flag;
      next_hrdata[usdp_pkg::STAT_TX_HOLDING_EMPTY_FLAG_BIT] = tx_cnt == '0;
      next_overrun                         = 1'b0;
    end
    // Receive path.
    if (rx_pop) begin
      next_rx_rd  = AW'(rx_rd + ONE[AW-1:0]);
      next_rx_cnt = rx_cnt - ONE;
    end
    if (in_valid) begin
      if (fifo_enable && rx_cnt == FULL && !rx_pop) begin
        next_overrun = 1'b1; // [R6]
      end else if (!fifo_enable && rx_cnt != '0 && !rx_pop) begin
        rx_we        = 1'b1; // [R4]
        rx_waddr     = rx_rd;
        next_overrun = 1'b1; // [R4]
      end else begin
        rx_we       = 1'b1;
        next_rx_wr  = AW'(rx_wr + ONE[AW-1:0]);
        next_rx_cnt = next_rx_cnt + ONE;
      end
    end
    // Transmit path: the head moves to the output stage as soon as it is free.
    tx_pop  = (tx_cnt != '0) & (~tx_char_valid | tx_char_take);
    tx_push = wr_pend & wr_alias; // [R12]
    if (tx_char_take) begin
      next_tx_char_valid = 1'b0;
    end
    if (tx_pop) begin
      next_tx_char       = tx_head; // [R7]
      next_tx_char_valid = 1'b1; // [R7]
      next_tx_rd         = AW'(tx_rd + ONE[AW-1:0]);
      next_tx_cnt        = tx_cnt - ONE;
    end
    if (tx_push) begin
      if (fifo_enable && tx_cnt == FULL && !tx_pop) begin
        tx_we = 1'b0; // [R11]
      end else if (!fifo_enable && tx_cnt != '0 && !tx_pop) begin
        tx_we    = 1'b1; // [R9]
        tx_waddr = tx_rd;
      end else begin
        tx_we       = 1'b1; // [R10]
        next_tx_wr  = AW'(tx_wr + ONE[AW-1:0]);
        next_tx_cnt = next_tx_cnt + ONE;
      end
    end
    // Changing the FIFO mode flushes both queues so no stale entries mix modes.
    if (wr_pend & wr_ctrl) begin
      next_fifo_enable = hwdata[usdp_pkg::CTRL_FIFO_EN_BIT];
      next_tx_ir_mode  = hwdata[usdp_pkg::CTRL_IR_MODE_BIT];
      if (next_fifo_enable != fifo_enable) begin
        next_rx_rd  = '0;
        next_rx_wr  = '0;
        next_rx_cnt = '0;
        next_tx_rd  = '0;
        next_tx_wr  = '0;
        next_tx_cnt = '0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_rd                 <= '0;
      rx_wr                 <= '0;
      rx_cnt                <= '0;
      tx_rd                 <= '0;
      tx_wr                 <= '0;
      tx_cnt                <= '0;
      wr_pend               <= 1'b0;
      wr_alias              <= 1'b0;
      wr_ctrl               <= 1'b0;
      hreadyout             <= 1'b1;
      hresp                 <= usdp_pkg::HRESP_OKAY;
      hrdata                <= usdp_pkg::RDATA_RESET;
      tx_char               <= usdp_pkg::CHAR_RESET;
      tx_char_valid         <= 1'b0;
      tx_ir_mode            <= usdp_pkg::IR_MODE_RESET;
      fifo_enable           <= usdp_pkg::FIFO_EN_RESET;
      overrun_flag          <= 1'b0;
      rx_data_ready_flag    <= 1'b0;
      tx_holding_empty_flag <= 1'b1;
    end else begin
      rx_rd                 <= next_rx_rd;
      rx_wr                 <= next_rx_wr;
      rx_cnt                <= next_rx_cnt;
      tx_rd                 <= next_tx_rd;
      tx_wr                 <= next_tx_wr;
      tx_cnt                <= next_tx_cnt;
      wr_pend               <= next_wr_pend;
      wr_alias              <= next_wr_alias;
      wr_ctrl               <= next_wr_ctrl;
      hreadyout             <= 1'b1;
      hresp                 <= usdp_pkg::HRESP_OKAY;
      hrdata                <= next_hrdata;
      tx_char               <= next_tx_char;
      tx_char_valid         <= next_tx_char_valid;
      tx_ir_mode            <= next_tx_ir_mode;
      fifo_enable           <= next_fifo_enable;
      overrun_flag          <= next_overrun;
      rx_data_ready_flag    <= next_rx_cnt != '0; // [R3]
      tx_holding_empty_flag <= next_tx_cnt == '0; // [R8] [R9]
    end
  end

  // Storage arrays carry no reset; an alias read on an empty receive FIFO still returns rx_mem[rx_rd], written or not.
  always_ff @(posedge mclk) begin
    if (rx_we) begin
      rx_mem[rx_waddr] <= rx_wdata;
    end
    if (tx_we) begin
      tx_mem[tx_waddr] <= hwdata[7:0];
    end
  end

  property p_rx_pop;
    @(posedge mclk) disable iff (!rst_n)
      rx_pop && !in_valid && !(wr_pend && wr_ctrl) |=> rx_cnt == $past(rx_cnt) - ONE;
  endproperty
  a_rx_pop: assert property (p_rx_pop) else $error("receive read did not pop"); // [R5]

  property p_rd_data;
    @(posedge mclk) disable iff (!rst_n)
      rx_pop |=> hrdata[7:0] == $past(rx_head) && hrdata[31:8] == '0;
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data not head byte"); // [R1]

  property p_rx_full;
    @(posedge mclk) disable iff (!rst_n)
      fifo_enable && rx_cnt == FULL && in_valid && !rx_pop && !(wr_pend && wr_ctrl)
      |=> rx_cnt == FULL && overrun_flag && $stable(rx_wr);
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("full receive FIFO changed"); // [R6]

  property p_rx_ovw;
    @(posedge mclk) disable iff (!rst_n)
      !fifo_enable && rx_cnt != '0 && in_valid && !rx_pop && !(wr_pend && wr_ctrl)
      |=> overrun_flag && rx_cnt == ONE && rx_head == $past(in_char);
  endproperty
  a_rx_ovw: assert property (p_rx_ovw) else $error("overwrite or overrun missing"); // [R4]

  property p_ovr_clr;
    @(posedge mclk) disable iff (!rst_n)
      acc && !hwrite && off == usdp_pkg::STAT_OFS && !in_valid |=> !overrun_flag;
  endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("status read kept overrun"); // [R4]

  property p_ir_sel;
    @(posedge mclk) disable iff (!rst_n)
      tx_ir_mode && ir_rx_valid && rx_cnt == '0 && !(wr_pend && wr_ctrl)
      |=> rx_data_ready_flag && rx_head == $past(ir_rx_char);
  endproperty
  a_ir_sel: assert property (p_ir_sel) else $error("infrared byte not captured"); // [R2]

  property p_tx_out;
    @(posedge mclk) disable iff (!rst_n)
      tx_pop |=> tx_char_valid && tx_char == $past(tx_head);
  endproperty
  a_tx_out: assert property (p_tx_out) else $error("transmit head not presented"); // [R7]

  property p_tx_holding_empty_flag_clr;
    @(posedge mclk) disable iff (!rst_n)
      !fifo_enable && tx_push && tx_char_valid && !tx_char_take
      |=> !tx_holding_empty_flag && tx_cnt == ONE;
  endproperty
  a_tx_holding_empty_flag_clr: assert property (p_tx_holding_empty_flag_clr) else $error("holding flag not cleared"); // [R9]

  property p_tx_fill;
    @(posedge mclk) disable iff (!rst_n)
      fifo_enable && tx_push && tx_cnt < FULL && !tx_pop && !(wr_pend && wr_ctrl)
      |=> tx_cnt == $past(tx_cnt) + ONE;
  endproperty
  a_tx_fill: assert property (p_tx_fill) else $error("transmit write not queued"); // [R10]

  property p_tx_drop;
    @(posedge mclk) disable iff (!rst_n)
      fifo_enable && tx_push && tx_cnt == FULL && !tx_pop
      |=> tx_cnt == FULL && $stable(tx_wr);
  endproperty
  a_tx_drop: assert property (p_tx_drop) else $error("write to full FIFO taken"); // [R11]

  c_rx_overrun: cover property (@(posedge mclk) disable iff (!rst_n)
    fifo_enable && rx_cnt == FULL && in_valid);
  c_tx_full: cover property (@(posedge mclk) disable iff (!rst_n)
    fifo_enable && tx_push && tx_cnt == FULL);
  c_alias_read: cover property (@(posedge mclk) disable iff (!rst_n) rx_pop);
  c_ir_send: cover property (@(posedge mclk) disable iff (!rst_n)
    tx_ir_mode && tx_pop);
endmodule
`default_nettype wire

// ---- sim/usdp_link_model.sv ----
// Far-side link model: takes transmitted characters and strobes received ones.
`default_nettype none
module usdp_link_model (
  // Clock
  input  wire logic       mclk,
  // Transmit side
  input  wire logic [7:0] tx_char,
  input  wire logic       tx_char_valid,
  input  wire logic       stall,
  output logic            tx_char_take,
  // Receive side
  output logic [7:0]      ser_rx_char,
  output logic            ser_rx_valid,
  output logic [7:0]      ir_rx_char,
  output logic            ir_rx_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] taken[$];
  initial begin
    tx_char_take = 1'b0;
    ser_rx_char  = 8'h00;
    ser_rx_valid = 1'b0;
    ir_rx_char   = 8'h00;
    ir_rx_valid  = 1'b0;
  end
  // A stalled link leaves the character standing, as a busy shifter would.
  always @(posedge mclk) begin
    if (tx_char_take && tx_char_valid) begin
      taken.push_back(tx_char);
    end
    tx_char_take <= tx_char_valid && !stall;
  end
  // The two lines carry different bytes so a wrong source select shows.
  task automatic send(input logic sv, input logic iv, input logic [7:0] c);
    @(posedge mclk);
    ser_rx_valid <= sv;
    ir_rx_valid  <= iv;
    ser_rx_char  <= c;
    ir_rx_char   <= ~c;
    @(posedge mclk);
    ser_rx_valid <= 1'b0;
    ir_rx_valid  <= 1'b0;
    ser_rx_char  <= ~c;
    ir_rx_char   <= c;
  endtask
endmodule
`default_nettype wire

// ---- sim/test_uart_shadow_data_port.sv ----
// Self-checking bench for the UART shadow data port.
`default_nettype none
module test_uart_shadow_data_port;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int          DEPTH = 4;
  localparam logic [31:0] BASE  = usdp_pkg::DATA_BASE;
  localparam logic [31:0] CTRL  = BASE + usdp_pkg::CTRL_OFS;
  localparam logic [31:0] STAT  = BASE + usdp_pkg::STAT_OFS;
  typedef struct packed {logic w; logic [31:0] a; logic [31:0] d;} usdp_row_t;
  localparam usdp_row_t ROWS[6] = '{'{1'b0, STAT, 32'h20}, '{1'b1, CTRL, 32'h3},
    '{1'b0, CTRL, 32'h3}, '{1'b1, BASE + 32'h80, 32'hff}, '{1'b0, BASE + 32'h80, 32'h0},
    '{1'b1, CTRL, 32'h0}};
  logic mclk, rst_n, hsel, hwrite, hreadyout, hresp, stall, tx_char_take, tx_ir_mode;
  logic ser_rx_valid, ir_rx_valid, tx_char_valid, rx_data_ready_flag;
  logic tx_holding_empty_flag, overrun_flag, fifo_enable;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  ser_rx_char, ir_rx_char, tx_char;
  logic [31:0] haddr, hwdata, hrdata, r;
  int          fails = 0;
  int          num_checks = 0;
  usdp_data_port #(.DEPTH(DEPTH)) uut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ser_rx_char(ser_rx_char), .ser_rx_valid(ser_rx_valid), .ir_rx_char(ir_rx_char),
    .ir_rx_valid(ir_rx_valid), .tx_char(tx_char), .tx_char_valid(tx_char_valid),
    .tx_char_take(tx_char_take), .tx_ir_mode(tx_ir_mode),
    .rx_data_ready_flag(rx_data_ready_flag), .tx_holding_empty_flag(tx_holding_empty_flag),
    .overrun_flag(overrun_flag), .fifo_enable(fifo_enable));
  usdp_link_model lnk (.mclk(mclk), .tx_char(tx_char), .tx_char_valid(tx_char_valid),
    .stall(stall), .tx_char_take(tx_char_take), .ser_rx_char(ser_rx_char),
    .ser_rx_valid(ser_rx_valid), .ir_rx_char(ir_rx_char), .ir_rx_valid(ir_rx_valid));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Single transfer; the data phase ends at the edge where hready is sampled high.
  task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic drain(input int n);
    for (int k = 0; k < 200 && lnk.taken.size() < n; k++) @(posedge mclk);
    chk(32'(lnk.taken.size()), 32'(n));
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    end_of_test();
  end
  initial begin
    rst_n = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = '0; stall = 1'b0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    r = 32'({rx_data_ready_flag, tx_holding_empty_flag, overrun_flag, tx_char_valid});
    chk(r, 32'h4);
    $display("test reset done");
    foreach (ROWS[i]) begin
      ahb(ROWS[i].w, ROWS[i].a, ROWS[i].d, r);
      if (!ROWS[i].w) chk(r, ROWS[i].d);
      chk(32'(hresp), 32'h0);
    end
    $display("test rows done");
    ahb(1'b1, CTRL, 32'h1, r);
    for (int i = 0; i <= DEPTH; i++) lnk.send(1'b1, 1'b0, 8'h10 + 8'(i));
    @(posedge mclk);
    chk(32'(overrun_flag), 32'h1);
    for (int i = 0; i < DEPTH; i++) begin
      ahb(1'b0, BASE + 32'(60 - 16 * i), 32'h0, r);
      chk(r, 32'h10 + 32'(i));
    end
    ahb(1'b0, STAT, 32'h0, r);
    chk(r, 32'h22);
    $display("test rx fifo done");
    ahb(1'b1, CTRL, 32'h3, r);
    @(posedge mclk);
    chk(32'(tx_ir_mode), 32'h1);
    lnk.send(1'b1, 1'b1, 8'h5a);
    ahb(1'b0, BASE, 32'h0, r);
    chk(r, 32'ha5);
    ahb(1'b1, CTRL, 32'h0, r);
    lnk.send(1'b1, 1'b0, 8'h11);
    lnk.send(1'b1, 1'b0, 8'h22);
    ahb(1'b0, STAT, 32'h0, r);
    chk(r, 32'h23);
    ahb(1'b0, BASE + 32'h4, 32'h0, r);
    chk(r, 32'h22);
    $display("test rx mode done");
    ahb(1'b1, CTRL, 32'h1, r);
    @(posedge mclk);
    chk(32'(fifo_enable), 32'h1);
    stall <= 1'b1;
    for (int i = 0; i < DEPTH + 2; i++) ahb(1'b1, BASE + 32'(8 + 4 * i), 32'h30 + 32'(i), r);
    chk(32'(tx_holding_empty_flag), 32'h0);
    stall <= 1'b0;
    drain(DEPTH + 1);
    foreach (lnk.taken[i]) chk(32'(lnk.taken[i]), 32'h30 + 32'(i));
    lnk.taken.delete();
    $display("test tx fifo done");
    ahb(1'b1, CTRL, 32'h0, r);
    stall <= 1'b1;
    chk(32'(tx_holding_empty_flag), 32'h1);
    ahb(1'b1, BASE + 32'h38, 32'h41, r);
    ahb(1'b1, BASE + 32'h3c, 32'h42, r);
    @(posedge mclk);
    chk(32'(tx_holding_empty_flag), 32'h0);
    ahb(1'b1, BASE + 32'h2c, 32'h43, r);
    stall <= 1'b0;
    drain(2);
    chk({24'h0, lnk.taken[0]}, 32'h41);
    chk({24'h0, lnk.taken[1]}, 32'h43);
    $display("test tx holding done");
    end_of_test();
  end
endmodule
`default_nettype wire
